/* temp_cond_consts.svh */
// constants for the six-channel temperature input conditioning block
// assumes: included by bare name from the package and the design modules
`ifndef TEMP_COND_CONSTS_SVH
`define TEMP_COND_CONSTS_SVH

`define CLK_PERIOD_NS 20
`define NS_PER_MS 1000000
`define NUM_CH 6
`define DATA_W 48
`define MS_W 16
`define LAST_CH 3'h5

// minimum sample period in ms per notch, integer format
`define MINP_INT_10HZ 16'h0066
`define MINP_INT_50HZ 16'h0016
`define MINP_INT_60HZ 16'h0013
`define MINP_INT_100HZ 16'h000C
`define MINP_INT_250HZ 16'h000A
`define MINP_INT_1000HZ 16'h000A
// floating point format floors, ms
`define MINP_FLT_10HZ 16'h0066
`define MINP_FLT_OTHER 16'h0019
`define MINP_LIN_MV 16'h0032

// effective resolution in bits
`define RES_BITS_LOW_NOTCH 5'h10
`define RES_BITS_250HZ 5'h0F
`define RES_BITS_1000HZ 5'h0A

// range limits; resistance in nano-ohm, voltage in nano-volt
`define LIM_R487_LO 48'sd859068653
`define LIM_R487_HI 48'sd507862000000
`define LIM_R1000_LO 48'sd2000000000
`define LIM_R1000_HI 48'sd1016502000000
`define LIM_R2000_LO 48'sd4000000000
`define LIM_R2000_HI 48'sd2033780000000
`define LIM_R4080_LO 48'sd8000000000
`define LIM_R4080_HI 48'sd4068392000000
`define LIM_MV78_LO -48'sd15158360
`define LIM_MV78_HI 48'sd79241000
`define LIM_MV30_LO -48'sd15803230
`define LIM_MV30_HI 48'sd31396000

// alarm slot positions
`define ALM_HIGH_HIGH 0
`define ALM_HIGH 1
`define ALM_LOW 2
`define ALM_LOW_LOW 3

`endif

/* temp_cond_pkg.sv */
// types shared by the temperature input conditioning modules
// assumes: the constants header sits in the same folder
`include "temp_cond_consts.svh"

package temp_cond_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_FILTER = 2'b11,
    ST_CAST = 2'b10
  } state_t;

  // code 0 means the owner left the notch unconfigured
  typedef enum logic [2:0] {
    NOTCH_UNSET = 3'h0,
    NOTCH_10HZ = 3'h1,
    NOTCH_50HZ = 3'h2,
    NOTCH_60HZ = 3'h3,
    NOTCH_100HZ = 3'h4,
    NOTCH_250HZ = 3'h5,
    NOTCH_1000HZ = 3'h6,
    NOTCH_BAD = 3'h7
  } notch_t;

  typedef enum logic [2:0] {
    RANGE_R487 = 3'h0,
    RANGE_R1000 = 3'h1,
    RANGE_R2000 = 3'h2,
    RANGE_R4080 = 3'h3,
    RANGE_MV78 = 3'h4,
    RANGE_MV30 = 3'h5
  } range_t;

  typedef struct packed {
    logic [2:0] channel;
    logic fresh;
    logic [3:0] alarms;
    logic low;
    logic high;
    logic signed [`DATA_W-1:0] value;
  } cast_word_t;

endpackage

/* lag_filter_if.sv */
// request and answer signals between the channel sequencer and the lag filter
// assumes: both ends share one clock; start is a one-cycle pulse
`timescale 1ns/1ps
`include "temp_cond_consts.svh"

interface lag_filter_if;
  logic start;
  logic signed [`DATA_W-1:0] x;
  logic signed [`DATA_W-1:0] y_prev;
  logic [`MS_W-1:0] dt_ms;
  logic [`MS_W-1:0] ta_ms;
  logic done;
  logic signed [`DATA_W-1:0] y;

  modport ctrl (output start, x, y_prev, dt_ms, ta_ms, input done, y);
  modport stage (input start, x, y_prev, dt_ms, ta_ms, output done, y);
endinterface

/* lag_filter.sv */
// first order lag filter shared by all channels, one request at a time
// assumes: no new start while a request is in progress
`timescale 1ns/1ps
`include "temp_cond_consts.svh"

module lag_filter (
  input wire logic mclk,
  input wire logic rst_b,
  lag_filter_if.stage f
);
  logic busy_reg;
  logic apply_reg;
  logic done_reg;
  logic [4:0] cnt_reg;
  logic [16:0] rem_reg;
  logic [16:0] den_reg;
  logic [31:0] quo_reg;
  logic signed [`DATA_W-1:0] x_reg;
  logic signed [`DATA_W-1:0] yp_reg;
  logic signed [`DATA_W-1:0] y_reg;

  // restoring divide gives alpha = dt * 2^16 / (dt + ta), at most 2^16
  wire logic [17:0] rem_sh = {rem_reg, quo_reg[31]};
  wire logic fits = rem_sh >= {1'b0, den_reg};
  wire logic [17:0] rem_sub = rem_sh - {1'b0, den_reg};
  wire logic signed [48:0] diff = {x_reg[47], x_reg} - {yp_reg[47], yp_reg};
  wire logic signed [66:0] prod = diff * $signed({1'b0, quo_reg[16:0]});
  // alpha never exceeds one, so the sum stays between old output and input
  wire logic signed [48:0] y_full = {yp_reg[47], yp_reg} + prod[64:16];

  assign f.done = done_reg;
  assign f.y = y_reg;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      busy_reg <= 1'b0;
      apply_reg <= 1'b0;
      done_reg <= 1'b0;
      cnt_reg <= 5'h00;
      rem_reg <= 17'h00000;
      den_reg <= 17'h00000;
      quo_reg <= 32'h00000000;
      x_reg <= 48'sh000000000000;
      yp_reg <= 48'sh000000000000;
      y_reg <= 48'sh000000000000;
    end else begin
      done_reg <= 1'b0;
      if (f.start) begin
        x_reg <= f.x;
        yp_reg <= f.y_prev;
        den_reg <= {1'b0, f.dt_ms} + {1'b0, f.ta_ms};
        quo_reg <= {f.dt_ms, 16'h0000};
        rem_reg <= 17'h00000;
        cnt_reg <= 5'h1F;
        busy_reg <= (f.ta_ms != 16'h0000);
        if (f.ta_ms == 16'h0000) begin
          y_reg <= f.x;
          done_reg <= 1'b1;
        end
      end else if (busy_reg) begin
        rem_reg <= fits ? rem_sub[16:0] : rem_sh[16:0];
        quo_reg <= {quo_reg[30:0], fits};
        cnt_reg <= cnt_reg - 5'h01;
        if (cnt_reg == 5'h00) begin
          busy_reg <= 1'b0;
          apply_reg <= 1'b1;
        end
      end else if (apply_reg) begin
        y_reg <= y_full[47:0];
        done_reg <= 1'b1;
        apply_reg <= 1'b0;
      end
    end
  end
endmodule

/* temperature_input_conditioning.sv */
// six-channel input conditioning: range checks, lag filter, process alarms,
// paced scanning and multicast of channel words through a two-entry buffer
// assumes: conv_value shows the converter reading of scan_channel at once;
// all inputs are synchronous to mclk
`timescale 1ns/1ps
`include "temp_cond_consts.svh"

module temperature_input_conditioning #(
  parameter int unsigned MS_CYCLES = `NS_PER_MS / `CLK_PERIOD_NS
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic float_format,
  input wire logic [`MS_W-1:0] rts_period_ms,
  input wire logic [`MS_W-1:0] packet_interval,
  input wire logic [5:0][2:0] range_sel,
  input wire logic [5:0][2:0] notch_sel,
  input wire logic [5:0] linearize,
  input wire logic [5:0][`MS_W-1:0] filter_time_constant,
  input wire logic signed [5:0][3:0][`DATA_W-1:0] alarm_limit,
  input wire logic signed [5:0][`DATA_W-1:0] alarm_deadband,
  input wire logic [5:0][3:0] alarm_latch_en,
  input wire logic [5:0][3:0] alarm_unlatch,
  output logic [2:0] scan_channel,
  input wire logic signed [`DATA_W-1:0] conv_value,
  output logic [`MS_W-1:0] min_period_ms,
  output logic [`MS_W-1:0] active_period_ms,
  output logic [5:0][4:0] resolution_bits,
  output logic [5:0] channel_low_limit_flag,
  output logic [5:0] channel_high_limit_flag,
  output logic [5:0] channel_fault,
  output logic [5:0][3:0] process_alarm,
  output logic mc_valid,
  input wire logic mc_ready,
  output temp_cond_pkg::cast_word_t mc_word
);

  function automatic temp_cond_pkg::notch_t notch_norm(input logic [2:0] c);
    if (c == 3'h0 || c == 3'h7)
      return temp_cond_pkg::NOTCH_60HZ;
    return temp_cond_pkg::notch_t'(c);
  endfunction

  function automatic logic signed [`DATA_W-1:0] range_limit(
    input logic [2:0] r, input logic hi);
    unique case (r)
      3'h0: return hi ? `LIM_R487_HI : `LIM_R487_LO;
      3'h2: return hi ? `LIM_R2000_HI : `LIM_R2000_LO;
      3'h3: return hi ? `LIM_R4080_HI : `LIM_R4080_LO;
      3'h4: return hi ? `LIM_MV78_HI : `LIM_MV78_LO;
      3'h5: return hi ? `LIM_MV30_HI : `LIM_MV30_LO;
      default: return hi ? `LIM_R1000_HI : `LIM_R1000_LO;
    endcase
  endfunction

  // one step of the four process alarms of a channel
  function automatic logic [3:0] alarm_step(
    input logic [3:0] cur, input logic signed [`DATA_W-1:0] v,
    input logic signed [3:0][`DATA_W-1:0] lim,
    input logic signed [`DATA_W-1:0] db,
    input logic [3:0] latch, input logic [3:0] unlatch);
    logic [3:0] res;
    logic cond;
    logic hold;
    res = 4'h0;
    for (int k = 0; k < 4; k++) begin
      // elements of a signed packed array are unsigned, so cast them back
      if (k < 2) begin
        cond = v > $signed(lim[k]);
        hold = v > $signed(lim[k]) - db;
      end else begin
        cond = v < $signed(lim[k]);
        hold = v < $signed(lim[k]) + db;
      end
      res[k] = cond | (cur[k] & hold);
      if (latch[k])
        res[k] = res[k] | (cur[k] & ~unlatch[k]);
    end
    return res;
  endfunction

  temp_cond_pkg::state_t state_reg;
  temp_cond_pkg::state_t state_next;
  logic [2:0] ch_reg;
  logic fresh_reg;
  logic rts_pend_reg;
  logic pi_pend_reg;
  logic [15:0] ms_cnt_reg;
  logic [`MS_W-1:0] rts_cnt_reg;
  logic [`MS_W-1:0] pi_cnt_reg;
  logic signed [`DATA_W-1:0] data_reg [`NUM_CH];
  logic [5:0] low_reg;
  logic [5:0] high_reg;
  logic [3:0] alarm_reg [`NUM_CH];
  temp_cond_pkg::cast_word_t buf_mem [2];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] count_reg;
  temp_cond_pkg::notch_t low_notch;
  logic [`MS_W-1:0] min_p;
  logic [3:0] alarm_next [`NUM_CH];

  lag_filter_if filt ();

  lag_filter u_filter (
    .mclk(mclk),
    .rst_b(rst_b),
    .f(filt.stage)
  );

  // lowest notch frequency has the longest minimum period
  always_comb begin
    low_notch = temp_cond_pkg::NOTCH_1000HZ;
    for (int i = 0; i < `NUM_CH; i++)
      if (notch_norm(notch_sel[i]) < low_notch)
        low_notch = notch_norm(notch_sel[i]);
  end

  always_comb begin
    min_p = `MINP_INT_60HZ;
    if (float_format) begin
      min_p = (low_notch == temp_cond_pkg::NOTCH_10HZ) ?
              `MINP_FLT_10HZ : `MINP_FLT_OTHER;
      for (int i = 0; i < `NUM_CH; i++)
        if (linearize[i] && range_sel[i] >= 3'h4 && range_sel[i] <= 3'h5 &&
            min_p < `MINP_LIN_MV)
          min_p = `MINP_LIN_MV;
    end else begin
      unique case (low_notch)
        temp_cond_pkg::NOTCH_10HZ: min_p = `MINP_INT_10HZ;
        temp_cond_pkg::NOTCH_50HZ: min_p = `MINP_INT_50HZ;
        temp_cond_pkg::NOTCH_100HZ: min_p = `MINP_INT_100HZ;
        temp_cond_pkg::NOTCH_250HZ: min_p = `MINP_INT_250HZ;
        temp_cond_pkg::NOTCH_1000HZ: min_p = `MINP_INT_1000HZ;
        default: min_p = `MINP_INT_60HZ;
      endcase
    end
  end

  assign min_period_ms = min_p;
  assign active_period_ms = (rts_period_ms < min_p) ? min_p : rts_period_ms;

  for (genvar g = 0; g < `NUM_CH; g++) begin : g_ch
    wire temp_cond_pkg::notch_t nn = notch_norm(notch_sel[g]);
    assign resolution_bits[g] =
      (nn == temp_cond_pkg::NOTCH_1000HZ) ? `RES_BITS_1000HZ :
      (nn == temp_cond_pkg::NOTCH_250HZ) ? `RES_BITS_250HZ :
      `RES_BITS_LOW_NOTCH;
    wire logic upd = state_reg == temp_cond_pkg::ST_FILTER && filt.done &&
                     ch_reg == 3'(g);
    // in the cycle the filter finishes, the alarm uses filt.y, which is not yet stored
    wire logic signed [`DATA_W-1:0] v = upd ? filt.y : data_reg[g];
    assign alarm_next[g] = float_format ?
      alarm_step(alarm_reg[g], v, alarm_limit[g], alarm_deadband[g],
                 alarm_latch_en[g], alarm_unlatch[g]) : 4'h0;
    assign process_alarm[g] = alarm_reg[g];
  end

  // millisecond tick and the two period timers
  wire logic ms_tick = ms_cnt_reg == 16'(MS_CYCLES - 1);
  wire logic rts_exp = ms_tick && rts_cnt_reg >= active_period_ms - 16'h0001;
  wire logic pi_exp = ms_tick && packet_interval != 16'h0000 &&
                      pi_cnt_reg >= packet_interval - 16'h0001;
  wire logic idle = state_reg == temp_cond_pkg::ST_IDLE;
  wire logic take_rts = idle && rts_pend_reg;
  wire logic take_pi = idle && !rts_pend_reg && pi_pend_reg;
  wire logic buf_in_ready = count_reg != 2'h2;
  wire logic push = state_reg == temp_cond_pkg::ST_CAST && buf_in_ready;
  wire logic pop = mc_valid && mc_ready;
  wire logic last_ch = ch_reg == `LAST_CH;

  assign filt.start = state_reg == temp_cond_pkg::ST_SAMPLE;
  assign filt.x = conv_value;
  assign filt.y_prev = data_reg[ch_reg];
  assign filt.dt_ms = active_period_ms;
  assign filt.ta_ms = float_format ? filter_time_constant[ch_reg] :
                      16'h0000;
  assign scan_channel = ch_reg;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      temp_cond_pkg::ST_IDLE:
        if (take_rts)
          state_next = temp_cond_pkg::ST_SAMPLE;
        else if (take_pi)
          state_next = temp_cond_pkg::ST_CAST;
      temp_cond_pkg::ST_SAMPLE:
        state_next = temp_cond_pkg::ST_FILTER;
      temp_cond_pkg::ST_FILTER:
        if (filt.done)
          state_next = last_ch ? temp_cond_pkg::ST_CAST :
                       temp_cond_pkg::ST_SAMPLE;
      temp_cond_pkg::ST_CAST:
        if (push && last_ch)
          state_next = temp_cond_pkg::ST_IDLE;
    endcase
  end

  wire logic ch_wrap = (state_reg == temp_cond_pkg::ST_FILTER && filt.done &&
                        last_ch) || (push && last_ch) || idle;
  wire logic ch_step = (state_reg == temp_cond_pkg::ST_FILTER && filt.done) ||
                       push;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_reg <= temp_cond_pkg::ST_IDLE;
      ch_reg <= 3'h0;
      fresh_reg <= 1'b0;
      ms_cnt_reg <= 16'h0000;
      rts_cnt_reg <= 16'h0000;
      pi_cnt_reg <= 16'h0000;
      rts_pend_reg <= 1'b0;
      pi_pend_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ch_reg <= ch_wrap ? 3'h0 : (ch_step ? ch_reg + 3'h1 : ch_reg);
      if (idle)
        fresh_reg <= take_rts;
      ms_cnt_reg <= ms_tick ? 16'h0000 : ms_cnt_reg + 16'h0001;
      if (ms_tick)
        rts_cnt_reg <= rts_exp ? 16'h0000 : rts_cnt_reg + 16'h0001;
      if (ms_tick)
        pi_cnt_reg <= pi_exp ? 16'h0000 : pi_cnt_reg + 16'h0001;
      // a new expiry in the cycle its request is taken is kept
      rts_pend_reg <= rts_exp | (rts_pend_reg & ~take_rts);
      pi_pend_reg <= pi_exp | (pi_pend_reg & ~take_pi);
    end
  end

  wire logic signed [`DATA_W-1:0] lo_lim = range_limit(range_sel[ch_reg], 1'b0);
  wire logic signed [`DATA_W-1:0] hi_lim = range_limit(range_sel[ch_reg], 1'b1);

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      low_reg <= 6'h00;
      high_reg <= 6'h00;
    end else if (filt.start) begin
      low_reg[ch_reg] <= conv_value <= lo_lim;
      high_reg[ch_reg] <= conv_value >= hi_lim;
    end
  end

  assign channel_low_limit_flag = low_reg;
  assign channel_high_limit_flag = high_reg;
  assign channel_fault = low_reg | high_reg;

  always_ff @(posedge mclk) begin
    for (int i = 0; i < `NUM_CH; i++) begin
      if (!rst_b) begin
        data_reg[i] <= 48'sh000000000000;
        alarm_reg[i] <= 4'h0;
      end else begin
        alarm_reg[i] <= alarm_next[i];
        if (state_reg == temp_cond_pkg::ST_FILTER && filt.done &&
            ch_reg == 3'(i))
          data_reg[i] <= filt.y;
      end
    end
  end

  // two-entry buffer keeps every word while the owner stalls mc_ready
  wire temp_cond_pkg::cast_word_t cast_in = '{
    channel: ch_reg,
    fresh: fresh_reg,
    alarms: alarm_reg[ch_reg],
    low: low_reg[ch_reg],
    high: high_reg[ch_reg],
    value: data_reg[ch_reg]
  };

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
      buf_mem[0] <= '0;
      buf_mem[1] <= '0;
    end else begin
      if (push) begin
        buf_mem[wr_ptr_reg] <= cast_in;
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop)
        rd_ptr_reg <= ~rd_ptr_reg;
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  assign mc_valid = count_reg != 2'h0;
  assign mc_word = buf_mem[rd_ptr_reg];

endmodule

/* temp_cond_properties.sv */
// concurrent checks on the ports of the conditioning block
// assumes: one clock, mclk, with rst_b as synchronous active low reset
`timescale 1ns/1ps

module temp_cond_properties (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic float_format,
  input wire logic [15:0] rts_period_ms,
  input wire logic [5:0][2:0] range_sel,
  input wire logic [5:0][2:0] notch_sel,
  input wire logic [5:0] linearize,
  input wire logic [5:0][3:0] alarm_latch_en,
  input wire logic [5:0][3:0] alarm_unlatch,
  input wire logic [15:0] min_period_ms,
  input wire logic [15:0] active_period_ms,
  input wire logic [5:0][4:0] resolution_bits,
  input wire logic [5:0] channel_low_limit_flag,
  input wire logic [5:0] channel_high_limit_flag,
  input wire logic [5:0] channel_fault,
  input wire logic [5:0][3:0] process_alarm,
  input wire logic mc_valid,
  input wire logic mc_ready,
  input temp_cond_pkg::cast_word_t mc_word
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_fault_or: assert property (
    channel_fault == (channel_low_limit_flag | channel_high_limit_flag))
    else $error("fault bits differ from range flags");
  a_res_bits: assert property (
    resolution_bits[0] == (notch_sel[0] == 3'h6 ? 5'h0A :
      notch_sel[0] == 3'h5 ? 5'h0F : 5'h10))
    else $error("resolution does not follow notch");
  a_active_max: assert property (
    active_period_ms == (rts_period_ms > min_period_ms ?
      rts_period_ms : min_period_ms))
    else $error("active period is not the larger period");
  a_float_floor: assert property (
    float_format |-> min_period_ms >= 16'h0019)
    else $error("float period below 25 ms");
  a_lowest_notch: assert property (
    notch_sel[3] == 3'h1 |-> min_period_ms == 16'h0066)
    else $error("lowest notch does not set module period");
  a_lin_floor: assert property (
    float_format && linearize[4] && range_sel[4] == 3'h5
      |-> min_period_ms >= 16'h0032)
    else $error("linearised mV period below 50 ms");
  a_default_notch: assert property (
    !float_format && notch_sel == '0 |-> min_period_ms == 16'h0013)
    else $error("unset notch not treated as 60 Hz");
  a_int_quiet: assert property (
    !float_format && $past(!float_format) |-> process_alarm == '0)
    else $error("process alarm in integer format");
  a_word_hold: assert property (
    mc_valid && !mc_ready |=> mc_valid && $stable(mc_word))
    else $error("stalled word changed or dropped");
  a_latch_hold: assert property (
    float_format && alarm_latch_en[2][2] && process_alarm[2][2] &&
      !alarm_unlatch[2][2] ##1 float_format |-> process_alarm[2][2])
    else $error("latched alarm cleared without unlatch");

  c_taken: cover property (mc_valid && mc_ready);
  c_stall: cover property (mc_valid && !mc_ready);
  c_alarm: cover property (float_format && process_alarm != '0);
  c_latch: cover property (alarm_latch_en[2][2] && process_alarm[2][2]);
endmodule

bind temperature_input_conditioning temp_cond_properties u_props (
  .mclk, .rst_b, .float_format, .rts_period_ms, .range_sel, .notch_sel,
  .linearize, .alarm_latch_en, .alarm_unlatch, .min_period_ms,
  .active_period_ms, .resolution_bits, .channel_low_limit_flag,
  .channel_high_limit_flag, .channel_fault, .process_alarm, .mc_valid,
  .mc_ready, .mc_word);

/* owner_model.sv */
// owner side that takes multicast words, with a stall input
// assumes: same clock and reset as the block
`timescale 1ns/1ps
`include "temp_cond_consts.svh"

module owner_model (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic stall,
  input wire logic mc_valid,
  input temp_cond_pkg::cast_word_t mc_word,
  output logic mc_ready,
  output logic order_err,
  output logic [15:0] fresh_cnt,
  output logic [15:0] stale_cnt,
  output temp_cond_pkg::cast_word_t [5:0] seen
);
  logic [2:0] next_ch;

  // ready is registered, so a stall takes one cycle to show
  always @(posedge mclk) begin
    if (!rst_b) begin
      mc_ready <= 1'b0;
      order_err <= 1'b0;
      fresh_cnt <= 16'h0000;
      stale_cnt <= 16'h0000;
      seen <= '0;
      next_ch <= 3'h0;
    end else begin
      mc_ready <= !stall;
      if (mc_valid && mc_ready) begin
        seen[mc_word.channel] <= mc_word;
        if (mc_word.channel !== next_ch) order_err <= 1'b1;
        next_ch <= (next_ch == `LAST_CH) ? 3'h0 : next_ch + 3'h1;
        if (mc_word.fresh) fresh_cnt <= fresh_cnt + 16'h0001;
        else stale_cnt <= stale_cnt + 16'h0001;
      end
    end
  end
endmodule

/* temperature_input_conditioning_test.sv */
// self-checking bench for the conditioning block
// assumes: owner_model and the checker file are compiled first
`timescale 1ns/1ps
`include "temp_cond_consts.svh"

module temperature_input_conditioning_test;
  localparam logic signed [47:0] u = 48'sh00174876E800;
  logic mclk, rst_b, float_format, mc_valid, mc_ready, stall, order_err;
  logic [15:0] rts_period_ms, packet_interval, min_period_ms;
  logic [15:0] active_period_ms, fresh_cnt, stale_cnt, n0, s0, e;
  logic [5:0][2:0] range_sel, notch_sel;
  logic [5:0] linearize, lo_flag, hi_flag, fault;
  logic [5:0][15:0] filter_time_constant;
  logic signed [5:0][3:0][47:0] alarm_limit;
  logic signed [5:0][47:0] alarm_deadband, conv_tab;
  logic [5:0][3:0] alarm_latch_en, alarm_unlatch, process_alarm;
  logic [2:0] scan_channel;
  logic signed [47:0] conv_value;
  logic [5:0][4:0] resolution_bits;
  temp_cond_pkg::cast_word_t mc_word;
  temp_cond_pkg::cast_word_t [5:0] seen;
  logic [15:0] mint [8] = '{16'h0013, 16'h0066, 16'h0016, 16'h0013,
    16'h000C, 16'h000A, 16'h000A, 16'h0013};
  logic [4:0] res_tab [8] = '{5'h10, 5'h10, 5'h10, 5'h10, 5'h10, 5'h0F,
    5'h0A, 5'h10};
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;

  // the converter answers at once for the channel being read
  assign conv_value = conv_tab[scan_channel];

  temperature_input_conditioning #(.MS_CYCLES(10)) dut (
    .mclk(mclk), .rst_b(rst_b), .float_format(float_format),
    .rts_period_ms(rts_period_ms), .packet_interval(packet_interval),
    .range_sel(range_sel), .notch_sel(notch_sel), .linearize(linearize),
    .filter_time_constant(filter_time_constant),
    .alarm_limit(alarm_limit), .alarm_deadband(alarm_deadband),
    .alarm_latch_en(alarm_latch_en), .alarm_unlatch(alarm_unlatch),
    .scan_channel(scan_channel), .conv_value(conv_value),
    .min_period_ms(min_period_ms), .active_period_ms(active_period_ms),
    .resolution_bits(resolution_bits), .channel_low_limit_flag(lo_flag),
    .channel_high_limit_flag(hi_flag), .channel_fault(fault),
    .process_alarm(process_alarm), .mc_valid(mc_valid),
    .mc_ready(mc_ready), .mc_word(mc_word));

  owner_model owner (
    .mclk(mclk), .rst_b(rst_b), .stall(stall), .mc_valid(mc_valid),
    .mc_word(mc_word), .mc_ready(mc_ready), .order_err(order_err),
    .fresh_cnt(fresh_cnt), .stale_cnt(stale_cnt), .seen(seen));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic check(input string name, input logic [63:0] got, exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic final_report;
    if (error_cnt == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic wait_words(input logic [15:0] n);
    for (int k = 0; k < 3000 && fresh_cnt < n; k++) @(negedge mclk);
    check("fresh words", fresh_cnt >= n, 1'b1);
  endtask

  // a hang ends the run as a failure instead of running forever
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      final_report();
    end
  end

  initial begin
    rst_b = 1'b0;
    float_format = 1'b0;
    stall = 1'b1;
    rts_period_ms = 16'h000A;
    packet_interval = 16'h0000;
    range_sel = {3'h0, 3'h5, 3'h4, 3'h1, 3'h1, 3'h1};
    notch_sel = {6{3'h6}};
    linearize = 6'h00;
    filter_time_constant = {{3{16'h0019}}, 16'h0000, {2{16'h0019}}};
    for (int c = 0; c < 6; c++) alarm_limit[c] = {48'h800000000000,
      48'h800000000000, 48'h7FFFFFFFFFFF, 48'h7FFFFFFFFFFF};
    alarm_limit[2] = {48'h0, u * 4'hB, u * 5'h14, u * 4'h9};
    alarm_limit[0][1] = u * 4'h5;
    alarm_deadband = '0;
    alarm_deadband[2] = u * 4'h2;
    alarm_latch_en = '0;
    alarm_unlatch = '0;
    conv_tab = {`LIM_R487_LO, `LIM_MV30_HI, 48'sh0, u * 4'hA,
      `LIM_R1000_HI, u * 4'h4};
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    tick(250);
    check("stalled valid", mc_valid, 1'b1);
    check("nothing taken", fresh_cnt, 16'h0000);
    @(posedge mclk);
    stall <= 1'b0;
    wait_words(16'h0006);
    check("order", order_err, 1'b0);
    check("word flags", {seen[5].low, seen[4].high, seen[1].high,
      seen[0].high}, 4'hE);
    for (int c = 0; c < 6; c++) begin
      check("word channel", seen[c].channel, c[2:0]);
      check("word value", seen[c].value, conv_tab[c]);
    end
    check("low flags", lo_flag, 6'h20);
    check("high flags", hi_flag, 6'h12);
    check("fault", fault, 6'h32);
    check("int alarms", process_alarm, 24'h000000);
    for (int f = 0; f < 2; f++)
      for (int n = 0; n < 8; n++) begin
        @(posedge mclk);
        float_format <= f[0];
        notch_sel <= {6{n[2:0]}};
        @(negedge mclk);
        e = f ? (n == 1 ? 16'h0066 : 16'h0019) : mint[n];
        check("min period", min_period_ms, e);
        check("active", active_period_ms, e);
        check("resolution", resolution_bits[1], res_tab[n]);
      end
    @(posedge mclk);
    float_format <= 1'b0;
    notch_sel <= {3'h6, 3'h6, 3'h1, 3'h6, 3'h6, 3'h6};
    @(negedge mclk);
    check("lowest notch", min_period_ms, 16'h0066);
    @(posedge mclk);
    float_format <= 1'b1;
    notch_sel <= {6{3'h6}};
    linearize <= 6'h10;
    @(negedge mclk);
    check("linearised", min_period_ms, 16'h0032);
    @(posedge mclk);
    float_format <= 1'b0;
    linearize <= 6'h00;
    rts_period_ms <= 16'h00C8;
    packet_interval <= 16'h0003;
    tick(40);
    n0 = fresh_cnt;
    s0 = stale_cnt;
    tick(300);
    check("no rescan", fresh_cnt, n0);
    check("packet casts", stale_cnt > s0, 1'b1);
    // second reset clears timers and stored values, so the filter starts at 0
    @(posedge mclk);
    rst_b <= 1'b0;
    float_format <= 1'b1;
    rts_period_ms <= 16'h0019;
    packet_interval <= 16'h0000;
    notch_sel <= {6{3'h3}};
    range_sel <= {3'h3, 3'h5, 3'h2, 3'h1, 3'h1, 3'h1};
    conv_tab[0] <= u * 4'h8;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    wait_words(16'h0006);
    check("filtered", seen[0].value, u * 4'h4);
    check("unfiltered", seen[2].value, u * 4'hA);
    check("range codes", {hi_flag, lo_flag}, 12'h4A8);
    check("word alarms", seen[2].alarms, 4'h5);
    check("alarms", process_alarm[2], 4'h5);
    check("filtered alarm", process_alarm[0], 4'h0);
    wait_words(16'h000C);
    check("filtered step", seen[0].value, u * 4'h6);
    check("filtered alarm", process_alarm[0], 4'h2);
    @(posedge mclk);
    alarm_limit[2][0] <= u * 4'hB;
    tick(3);
    check("deadband hold", process_alarm[2][0], 1'b1);
    @(posedge mclk);
    alarm_limit[2][0] <= u * 4'hD;
    tick(3);
    check("alarm cleared", process_alarm[2][0], 1'b0);
    @(posedge mclk);
    alarm_latch_en[2][2] <= 1'b1;
    @(posedge mclk);
    alarm_limit[2][2] <= 48'sh0;
    tick(3);
    check("latched", process_alarm[2][2], 1'b1);
    @(posedge mclk);
    alarm_unlatch[2][2] <= 1'b1;
    @(posedge mclk);
    alarm_unlatch[2][2] <= 1'b0;
    tick(2);
    check("unlatched", process_alarm[2][2], 1'b0);
    final_report();
  end
endmodule
